// ### flash_pkg.sv
// package: flash controller constants, register map, types
package flash_pkg;

	// ****************************************
	// memory organisation
	// ****************************************
	localparam int SECTOR_COUNT = 8;
	localparam int SECTOR_BYTES = 2048;
	localparam int PAGE_BYTES = 64;
	localparam int ARRAY_BYTES = SECTOR_COUNT * SECTOR_BYTES;
	localparam int ADDR_W = 14;
	localparam int SEC_POS = 11;
	localparam int PAGE_POS = 6;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	localparam logic [15:0] BOOT_ROM_LO = 16'hFF00;
	localparam logic [15:0] BOOT_ROM_HI = 16'hFFEF;
	localparam logic [15:0] SERVICE_ENTRY = 16'hFF03;
	localparam logic [15:0] RESET_START = 16'h0000;
	localparam logic [7:0] VECTOR_LOW = 8'h00;
	localparam logic [7:0] BOOT_VECTOR_DEFAULT = 8'h3F;
	localparam logic BOOT_STATUS_DEFAULT = 1'b1;
	localparam int LOADER_BYTES = 512;

	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] DATA_OFS = 8'h04;
	localparam logic [7:0] ADDRL_OFS = 8'h08;
	localparam logic [7:0] ADDRH_OFS = 8'h0C;
	localparam logic [7:0] CRC_OFS = 8'h10;
	localparam logic [7:0] BOOT_OFS = 8'h14;
	localparam logic [7:0] SECURE_OFS = 8'h18;
	localparam logic [7:0] READ_OFS = 8'h1C;

	// control/status fields
	localparam int CMD_POS = 0;
	localparam int CRC_ALL_POS = 3;
	localparam int GO_POS = 4;
	localparam int BUSY_POS = 7;
	localparam int DENIED_POS = 8;
	localparam int VALID_POS = 9;
	localparam int BOOT_STAT_POS = 8;

	// crc
	localparam logic [31:0] CRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;

	// axi responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0] {
		CMD_LOAD = 3'h0,
		CMD_PROG_PAGE = 3'h1,
		CMD_ERASE_BYTE = 3'h2,
		CMD_ERASE_PAGE = 3'h3,
		CMD_ERASE_SECTOR = 3'h4,
		CMD_CRC = 3'h5,
		CMD_READ = 3'h6,
		CMD_CLEAR_BUF = 3'h7
	} cmd_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [7:0] wdata;
		logic we;
	} array_req_t;

	typedef struct packed {
		logic [15:0] start_addr;
		logic boot_status;
		logic [7:0] boot_vector;
	} boot_t;

endpackage

// ### flash_crc.sv
// crc32 byte engine used for array verification
`timescale 1ns/100ps
module flash_crc (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clear,
	input wire logic step,
	input wire logic [7:0] data,
	output logic [31:0] crc
);
	logic [31:0] crc_r;
	logic [31:0] crc_nxt;
	logic [31:0] c;

	// one byte per cycle, msb first
	always_comb begin
		c = crc_r;
		for (int i = 7; i >= 0; i--) begin
			if (c[31] ^ data[i]) begin
				c = {c[30:0], 1'b0} ^ flash_pkg::CRC_POLY;
			end else begin
				c = {c[30:0], 1'b0};
			end
		end
		crc_nxt = crc_r;
		if (clear) begin
			crc_nxt = flash_pkg::CRC_INIT;
		end else if (step) begin
			crc_nxt = c;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			crc_r <= flash_pkg::CRC_INIT;
		end else begin
			crc_r <= crc_nxt;
		end
	end

	assign crc = crc_r;
endmodule

// ### code_flash_program_boot_control.sv
// flash program/erase sequencer, crc verify, secured reads and reset start address
// Operation
// - eight 2 kB sectors, largest variant
// - sectors split into 64-byte pages
// - erase whole sector, page or byte
// - 64-byte page buffer programs 1..64 bytes
// - table reads of secured sectors refused
// - byte readback of unsecured sectors; 32-bit crc sector/all
// - boot rom FF00H..FFEFH above user space
// - four special registers program and erase
// - boot status zero starts at 0000H
// - otherwise start at boot vector, 00H
// - default boot vector 3FH, entry 3F00H
// - factory loader in top 512 bytes
// - two-wire serial programming link
// - boot vector reprogrammable for custom loader
`timescale 1ns/100ps
module code_flash_program_boot_control (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [15:0] start_addr,
	output logic in_boot_rom,
	input wire logic [15:0] fetch_addr,
	input wire logic prog_clk,
	input wire logic prog_data
);
	// ****************************************
	// storage
	// ****************************************
	// cells power up erased and keep their contents through aresetn
	logic [7:0] mem [flash_pkg::ARRAY_BYTES] = '{default: flash_pkg::ERASED_BYTE};
	logic [7:0] page_buf [flash_pkg::PAGE_BYTES];
	logic [flash_pkg::PAGE_BYTES-1:0] buf_used_r;
	logic [flash_pkg::PAGE_BYTES-1:0] buf_used_nxt;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b00001,
		ST_PROG = 5'b00010,
		ST_ERASE = 5'b00100,
		ST_CRC = 5'b01000,
		ST_BOOTSET = 5'b10000
	} state_t;

	state_t state_r, state_nxt;
	logic [flash_pkg::ADDR_W-1:0] cnt_r, cnt_nxt;
	logic [flash_pkg::ADDR_W-1:0] end_r, end_nxt;
	logic [7:0] data_r, data_nxt;
	logic [7:0] addrl_r, addrl_nxt;
	logic [7:0] addrh_r, addrh_nxt;
	logic [2:0] cmd_r, cmd_nxt;
	logic crc_all_r, crc_all_nxt;
	logic denied_r, denied_nxt;
	logic [7:0] rd_byte_r, rd_byte_nxt;
	logic rd_valid_r, rd_valid_nxt;
	logic [flash_pkg::SECTOR_COUNT-1:0] secure_r = '0;
	logic [flash_pkg::SECTOR_COUNT-1:0] secure_nxt;
	logic [7:0] vec_stage_r = flash_pkg::BOOT_VECTOR_DEFAULT;
	logic [7:0] vec_stage_nxt;
	logic boot_stat_stage_r = flash_pkg::BOOT_STATUS_DEFAULT;
	logic boot_stat_stage_nxt;
	flash_pkg::boot_t boot_r = '{flash_pkg::RESET_START, flash_pkg::BOOT_STATUS_DEFAULT,
		flash_pkg::BOOT_VECTOR_DEFAULT};
	flash_pkg::boot_t boot_nxt;
	logic started_r, started_nxt;

	// ****************************************
	// axi4-lite slave
	// ****************************************
	logic aw_ok_r, aw_ok_nxt, w_ok_r, w_ok_nxt;
	logic [7:0] awaddr_r, awaddr_nxt;
	logic [31:0] wdata_r, wdata_nxt;
	logic [3:0] wstrb_r, wstrb_nxt;
	logic bvalid_r, bvalid_nxt;
	logic [1:0] bresp_r, bresp_nxt;
	logic rvalid_r, rvalid_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	logic [1:0] rresp_r, rresp_nxt;
	logic wr_fire, rd_fire, map_hit;

	assign s_axi_awready = !aw_ok_r && !bvalid_r;
	assign s_axi_wready = !w_ok_r && !bvalid_r;
	assign s_axi_arready = !rvalid_r;
	assign s_axi_bvalid = bvalid_r;
	assign s_axi_bresp = bresp_r;
	assign s_axi_rvalid = rvalid_r;
	assign s_axi_rdata = rdata_r;
	assign s_axi_rresp = rresp_r;
	assign wr_fire = aw_ok_r && w_ok_r && !bvalid_r;
	assign rd_fire = s_axi_arvalid && !rvalid_r;

	function automatic logic mapped(input logic [7:0] a);
		mapped = a == flash_pkg::CTRL_OFS || a == flash_pkg::DATA_OFS || a == flash_pkg::ADDRL_OFS ||
			a == flash_pkg::ADDRH_OFS || a == flash_pkg::CRC_OFS || a == flash_pkg::BOOT_OFS ||
			a == flash_pkg::SECURE_OFS || a == flash_pkg::READ_OFS;
	endfunction

	assign map_hit = mapped(awaddr_r);

	always_comb begin
		aw_ok_nxt = aw_ok_r;
		w_ok_nxt = w_ok_r;
		awaddr_nxt = awaddr_r;
		wdata_nxt = wdata_r;
		wstrb_nxt = wstrb_r;
		bvalid_nxt = bvalid_r;
		bresp_nxt = bresp_r;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_ok_nxt = 1'b1;
			awaddr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_ok_nxt = 1'b1;
			wdata_nxt = s_axi_wdata;
			wstrb_nxt = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_ok_nxt = 1'b0;
			w_ok_nxt = 1'b0;
			bvalid_nxt = 1'b1;
			bresp_nxt = map_hit ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// ****************************************
	// register reads
	// ****************************************
	logic [31:0] crc_val;
	logic busy;
	assign busy = state_r != ST_IDLE;

	always_comb begin
		rvalid_nxt = rvalid_r;
		rdata_nxt = rdata_r;
		rresp_nxt = rresp_r;
		if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
		if (rd_fire) begin
			rvalid_nxt = 1'b1;
			rresp_nxt = mapped(s_axi_araddr) ? flash_pkg::RESP_OKAY : flash_pkg::RESP_SLVERR;
			rdata_nxt = 32'h00000000;
			unique case (s_axi_araddr)
				flash_pkg::CTRL_OFS: begin
					rdata_nxt[flash_pkg::CMD_POS +: 3] = cmd_r;
					rdata_nxt[flash_pkg::CRC_ALL_POS] = crc_all_r;
					rdata_nxt[flash_pkg::BUSY_POS] = busy;
					rdata_nxt[flash_pkg::DENIED_POS] = denied_r;
					rdata_nxt[flash_pkg::VALID_POS] = rd_valid_r;
				end
				flash_pkg::DATA_OFS: rdata_nxt[7:0] = data_r;
				flash_pkg::ADDRL_OFS: rdata_nxt[7:0] = addrl_r;
				flash_pkg::ADDRH_OFS: rdata_nxt[7:0] = addrh_r;
				flash_pkg::CRC_OFS: rdata_nxt = crc_val;
				flash_pkg::BOOT_OFS: begin
					rdata_nxt[7:0] = boot_r.boot_vector;
					rdata_nxt[flash_pkg::BOOT_STAT_POS] = boot_r.boot_status;
				end
				flash_pkg::SECURE_OFS: rdata_nxt[7:0] = secure_r;
				flash_pkg::READ_OFS: rdata_nxt[7:0] = rd_byte_r;
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// ****************************************
	// sequencer
	// ****************************************
	logic [flash_pkg::ADDR_W-1:0] taddr;
	logic [5:0] pofs;
	logic [2:0] sec;
	logic go;
	logic wr_ctrl;
	logic [2:0] wcmd;
	flash_pkg::array_req_t req;
	logic crc_clear, crc_step;
	logic prog_clk_q_r, prog_clk_q_nxt;
	assign prog_clk_q_nxt = prog_clk;

	assign taddr = {addrh_r[5:0], addrl_r};
	assign pofs = taddr[5:0];
	assign sec = taddr[flash_pkg::ADDR_W-1:flash_pkg::SEC_POS];
	assign wr_ctrl = wr_fire && awaddr_r == flash_pkg::CTRL_OFS && wstrb_r[0];
	assign wcmd = wdata_r[flash_pkg::CMD_POS +: 3];
	assign go = wr_ctrl && wdata_r[flash_pkg::GO_POS] && !busy;

	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		end_nxt = end_r;
		data_nxt = data_r;
		addrl_nxt = addrl_r;
		addrh_nxt = addrh_r;
		cmd_nxt = cmd_r;
		crc_all_nxt = crc_all_r;
		denied_nxt = denied_r;
		rd_byte_nxt = rd_byte_r;
		rd_valid_nxt = rd_valid_r;
		secure_nxt = secure_r;
		vec_stage_nxt = vec_stage_r;
		boot_stat_stage_nxt = boot_stat_stage_r;
		buf_used_nxt = buf_used_r;
		req = '0;
		crc_clear = 1'b0;
		crc_step = 1'b0;
		// special register writes, ignored while busy
		if (wr_fire && wstrb_r[0] && !busy) begin
			unique case (awaddr_r)
				flash_pkg::DATA_OFS: data_nxt = wdata_r[7:0];
				flash_pkg::ADDRL_OFS: addrl_nxt = wdata_r[7:0];
				flash_pkg::ADDRH_OFS: addrh_nxt = wdata_r[7:0];
				flash_pkg::SECURE_OFS: secure_nxt = secure_r | wdata_r[7:0]; // security only set
				flash_pkg::BOOT_OFS: begin
					vec_stage_nxt = wdata_r[7:0];
					boot_stat_stage_nxt = wdata_r[flash_pkg::BOOT_STAT_POS];
				end
				flash_pkg::CTRL_OFS: begin
					cmd_nxt = wcmd;
					crc_all_nxt = wdata_r[flash_pkg::CRC_ALL_POS];
				end
				default: ;
			endcase
		end
		// two-wire link: one bit per rising link clock, msb first, straight into the data register
		if (prog_clk && !prog_clk_q_r) begin
			data_nxt = {data_r[6:0], prog_data};
		end
		unique case (state_r)
			ST_IDLE: begin
				if (go) begin
					denied_nxt = 1'b0;
					unique case (flash_pkg::cmd_t'(wcmd))
						flash_pkg::CMD_LOAD: begin
							buf_used_nxt[pofs] = 1'b1;
						end
						flash_pkg::CMD_CLEAR_BUF: buf_used_nxt = '0;
						flash_pkg::CMD_PROG_PAGE: begin
							state_nxt = ST_PROG;
							cnt_nxt = {taddr[flash_pkg::ADDR_W-1:flash_pkg::PAGE_POS], 6'h00};
							end_nxt = {taddr[flash_pkg::ADDR_W-1:flash_pkg::PAGE_POS], 6'h3F};
						end
						flash_pkg::CMD_ERASE_BYTE: begin
							state_nxt = ST_ERASE;
							cnt_nxt = taddr;
							end_nxt = taddr;
						end
						flash_pkg::CMD_ERASE_PAGE: begin
							state_nxt = ST_ERASE;
							cnt_nxt = {taddr[flash_pkg::ADDR_W-1:flash_pkg::PAGE_POS], 6'h00};
							end_nxt = {taddr[flash_pkg::ADDR_W-1:flash_pkg::PAGE_POS], 6'h3F};
						end
						flash_pkg::CMD_ERASE_SECTOR: begin
							state_nxt = ST_ERASE;
							cnt_nxt = {sec, 11'h000};
							end_nxt = {sec, 11'h7FF};
						end
						flash_pkg::CMD_CRC: begin
							state_nxt = ST_CRC;
							crc_clear = 1'b1;
							cnt_nxt = wdata_r[flash_pkg::CRC_ALL_POS] ? '0 : {sec, 11'h000};
							end_nxt = wdata_r[flash_pkg::CRC_ALL_POS] ? '1 : {sec, 11'h7FF};
						end
						flash_pkg::CMD_READ: begin
							if (secure_r[sec]) begin
								denied_nxt = 1'b1;
								rd_valid_nxt = 1'b0;
								rd_byte_nxt = 8'h00;
							end else begin
								rd_byte_nxt = mem[taddr];
								rd_valid_nxt = 1'b1;
							end
						end
						default: ;
					endcase
				end else if (wr_fire && wstrb_r[0] && awaddr_r == flash_pkg::BOOT_OFS) begin
					state_nxt = ST_BOOTSET;
				end
			end
			ST_PROG: begin
				// programming only clears bits, so unloaded slots are left alone
				if (buf_used_r[cnt_r[5:0]]) begin
					req = '{addr: cnt_r, wdata: mem[cnt_r] & page_buf[cnt_r[5:0]], we: 1'b1};
				end
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == end_r) begin
					state_nxt = ST_IDLE;
					buf_used_nxt = '0;
				end
			end
			ST_ERASE: begin
				req = '{addr: cnt_r, wdata: flash_pkg::ERASED_BYTE, we: 1'b1};
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == end_r) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_CRC: begin
				crc_step = 1'b1;
				cnt_nxt = cnt_r + 1'b1;
				if (cnt_r == end_r) begin
					state_nxt = ST_IDLE;
				end
			end
			ST_BOOTSET: state_nxt = ST_IDLE; // vector commit takes one busy cycle
		endcase
	end

	// ****************************************
	// boot start address
	// ****************************************
	always_comb begin
		boot_nxt = boot_r;
		if (state_r == ST_BOOTSET) begin
			boot_nxt.boot_vector = vec_stage_r;
			boot_nxt.boot_status = boot_stat_stage_r;
		end
		// start address latched once after reset release
		if (!started_r) begin
			boot_nxt.start_addr = boot_r.boot_status ? {boot_r.boot_vector, flash_pkg::VECTOR_LOW}
				: flash_pkg::RESET_START;
		end
	end
	assign started_nxt = 1'b1;
	assign start_addr = boot_r.start_addr;
	// boot rom window sits above the 16k user array
	assign in_boot_rom = fetch_addr >= flash_pkg::BOOT_ROM_LO && fetch_addr <= flash_pkg::BOOT_ROM_HI;

	flash_crc u_crc (
		.aclk(aclk),
		.aresetn(aresetn),
		.clear(crc_clear),
		.step(crc_step),
		.data(mem[cnt_r]),
		.crc(crc_val)
	);

	// ****************************************
	// registers
	// ****************************************
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= ST_IDLE;
			cnt_r <= '0;
			end_r <= '0;
			data_r <= 8'h00;
			addrl_r <= 8'h00;
			addrh_r <= 8'h00;
			cmd_r <= 3'h0;
			crc_all_r <= 1'b0;
			denied_r <= 1'b0;
			rd_byte_r <= 8'h00;
			rd_valid_r <= 1'b0;
			buf_used_r <= '0;
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			awaddr_r <= 8'h00;
			wdata_r <= 32'h00000000;
			wstrb_r <= 4'h0;
			bvalid_r <= 1'b0;
			bresp_r <= 2'h0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h00000000;
			rresp_r <= 2'h0;
			started_r <= 1'b0;
			prog_clk_q_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			end_r <= end_nxt;
			data_r <= data_nxt;
			addrl_r <= addrl_nxt;
			addrh_r <= addrh_nxt;
			cmd_r <= cmd_nxt;
			crc_all_r <= crc_all_nxt;
			denied_r <= denied_nxt;
			rd_byte_r <= rd_byte_nxt;
			rd_valid_r <= rd_valid_nxt;
			buf_used_r <= buf_used_nxt;
			aw_ok_r <= aw_ok_nxt;
			w_ok_r <= w_ok_nxt;
			awaddr_r <= awaddr_nxt;
			wdata_r <= wdata_nxt;
			wstrb_r <= wstrb_nxt;
			bvalid_r <= bvalid_nxt;
			bresp_r <= bresp_nxt;
			rvalid_r <= rvalid_nxt;
			rdata_r <= rdata_nxt;
			rresp_r <= rresp_nxt;
			started_r <= started_nxt;
			prog_clk_q_r <= prog_clk_q_nxt;
		end
	end

	// non-volatile state: survives reset, models the flash cells; only the start address resets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_r.start_addr <= flash_pkg::RESET_START;
		end else begin
			boot_r.start_addr <= boot_nxt.start_addr;
		end
		secure_r <= secure_nxt;
		vec_stage_r <= vec_stage_nxt;
		boot_stat_stage_r <= boot_stat_stage_nxt;
		boot_r.boot_vector <= boot_nxt.boot_vector;
		boot_r.boot_status <= boot_nxt.boot_status;
		if (req.we) begin
			mem[req.addr] <= req.wdata;
		end
		if (state_r == ST_IDLE && go && flash_pkg::cmd_t'(wcmd) == flash_pkg::CMD_LOAD) begin
			page_buf[pofs] <= data_r;
		end
	end

endmodule

// ### flash_ctrl_props.sv
// assertions on the flash controller ports
`timescale 1ns/100ps
module flash_ctrl_props (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [15:0] start_addr,
	input wire logic in_boot_rom,
	input wire logic [15:0] fetch_addr
);
	// ****************
	// address capture and properties
	// ****************
	logic [7:0] aw_addr_r;
	logic [7:0] ar_addr_r;
	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready) begin
			aw_addr_r <= s_axi_awaddr;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ar_addr_r <= s_axi_araddr;
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	property p_rom;
		in_boot_rom == (fetch_addr >= flash_pkg::BOOT_ROM_LO && fetch_addr <= flash_pkg::BOOT_ROM_HI);
	endproperty
	a_rom: assert property (p_rom) else $error("boot rom flag wrong");
	property p_start;
		$changed(start_addr) |-> !$past(aresetn) || !$past(aresetn, 2) || !$past(aresetn, 3);
	endproperty
	a_start: assert property (p_start) else $error("start address moved outside reset");
	property p_bresp;
		s_axi_bvalid && aw_addr_r[1:0] == 2'h0
			|-> s_axi_bresp == (aw_addr_r > 8'h1C ? flash_pkg::RESP_SLVERR : flash_pkg::RESP_OKAY);
	endproperty
	a_bresp: assert property (p_bresp) else $error("write response code wrong");
	property p_rresp;
		s_axi_rvalid && ar_addr_r > 8'h1C |-> s_axi_rresp == flash_pkg::RESP_SLVERR && s_axi_rdata == 32'h0;
	endproperty
	a_rresp: assert property (p_rresp) else $error("unmapped read answer wrong");
	property p_bhold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped");
	property p_arready;
		s_axi_arready == !s_axi_rvalid;
	endproperty
	a_arready: assert property (p_arready) else $error("read address ready wrong");
	property p_rlat;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_blat;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid;
	endproperty
	a_blat: assert property (p_blat) else $error("write answer late");
	c_slverr: cover property (s_axi_bvalid && s_axi_bresp == flash_pkg::RESP_SLVERR);
	c_rom: cover property (in_boot_rom);
	c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind code_flash_program_boot_control flash_ctrl_props flash_ctrl_props_inst (.aclk, .aresetn, .s_axi_awaddr,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
	.start_addr, .in_boot_rom, .fetch_addr);

// ### core_fetch_model.sv
// core fetch model: start address, jumps and service calls
`timescale 1ns/100ps
module core_fetch_model (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [15:0] start_addr,
	input wire logic jump_en,
	input wire logic [15:0] jump_addr,
	input wire logic call_en,
	output logic [15:0] fetch_addr
);
	// ****************
	// fetch pointer
	// ****************
	logic [1:0] boot_cnt_r;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boot_cnt_r <= 2'h0;
			fetch_addr <= flash_pkg::RESET_START;
		end else if (boot_cnt_r != 2'h3) begin
			// start address settles late after release, so keep reloading it
			boot_cnt_r <= boot_cnt_r + 2'h1;
			fetch_addr <= start_addr;
		end else if (call_en) begin
			fetch_addr <= flash_pkg::SERVICE_ENTRY;
		end else if (jump_en) begin
			fetch_addr <= jump_addr;
		end else begin
			fetch_addr <= fetch_addr + 16'h0001;
		end
	end
endmodule

// ### tb_code_flash_program_boot_control.sv
// testbench for the flash program and boot controller
`timescale 1ns/100ps
module tb_code_flash_program_boot_control;
	// ****************
	// stimulus, scenarios and checks
	// ****************
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, in_boot_rom, jump_en, call_en;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rdat, c, v;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [15:0] start_addr, fetch_addr, jump_addr;
	int err_total, cmp_count;
	logic prog_clk, prog_data;
	code_flash_program_boot_control code_flash_program_boot_control_inst (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
		.s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .start_addr, .in_boot_rom, .fetch_addr, .prog_clk, .prog_data);
	core_fetch_model core_fetch_model_inst (.aclk, .aresetn, .start_addr, .jump_en, .jump_addr, .call_en,
		.fetch_addr);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s expected %h seen %h", n, e, g);
		end
	endtask
	task rst;
		aresetn <= 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (3) @(posedge aclk);
	endtask
	task wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic aw, w;
		aw = 1'b0;
		w = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!(aw && w)) begin
			@(posedge aclk);
			if (s_axi_awready && !aw) s_axi_awvalid <= 1'b0;
			if (s_axi_wready && !w) s_axi_wvalid <= 1'b0;
			aw |= s_axi_awready;
			w |= s_axi_wready;
		end
		do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
		rs = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task rd_reg(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
		rdat = s_axi_rdata;
		rs = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	// polls busy; a stuck busy is cut short by the watchdog
	task idle;
		do rd_reg(flash_pkg::CTRL_OFS); while (rdat[flash_pkg::BUSY_POS] === 1'b1);
	endtask
	task op(input logic [2:0] cm, input logic [13:0] a, input logic all);
		wr_reg(flash_pkg::ADDRL_OFS, {24'h0, a[7:0]});
		wr_reg(flash_pkg::ADDRH_OFS, {26'h0, a[13:8]});
		wr_reg(flash_pkg::CTRL_OFS, {27'h0, 1'b1, all, cm});
	endtask
	task tread(input logic [13:0] a);
		op(flash_pkg::CMD_READ, a, 1'b0);
		idle();
		c = rdat;
		rd_reg(flash_pkg::READ_OFS);
		v = rdat;
	endtask
	function automatic logic [31:0] crc_ff(input int n);
		logic [31:0] r;
		r = flash_pkg::CRC_INIT;
		for (int i = 0; i < n; i++) begin
			r ^= 32'hFF000000;
			for (int b = 0; b < 8; b++) r = r[31] ? (r << 1) ^ flash_pkg::CRC_POLY : r << 1;
		end
		return r;
	endfunction
	task t_boot;
		chk("start", {flash_pkg::BOOT_VECTOR_DEFAULT, flash_pkg::VECTOR_LOW}, start_addr);
		rd_reg(flash_pkg::BOOT_OFS);
		chk("boot", {23'h0, flash_pkg::BOOT_STATUS_DEFAULT, flash_pkg::BOOT_VECTOR_DEFAULT}, rdat);
		wr_reg(flash_pkg::BOOT_OFS, 32'h00000112);
		chk("start held", 32'h3F00, start_addr);
		rst();
		chk("custom start", 32'h1200, start_addr);
		wr_reg(flash_pkg::BOOT_OFS, 32'h00000012);
		rst();
		chk("plain start", flash_pkg::RESET_START, start_addr);
		wr_reg(flash_pkg::BOOT_OFS, 32'h0000013F);
		rst();
		$display("boot test done");
	endtask
	task automatic t_rom;
		logic [15:0] a [5] = '{16'hFEFF, 16'hFF00, 16'hFFEF, 16'hFFF0, 16'h3F00};
		foreach (a[i]) begin
			@(posedge aclk);
			jump_addr <= a[i];
			jump_en <= 1'b1;
			@(posedge aclk);
			jump_en <= 1'b0;
			@(posedge aclk);
			chk("rom", a[i] >= flash_pkg::BOOT_ROM_LO && a[i] <= flash_pkg::BOOT_ROM_HI, in_boot_rom);
		end
		call_en <= 1'b1;
		@(posedge aclk);
		call_en <= 1'b0;
		@(posedge aclk);
		chk("service", 32'h1, in_boot_rom);
		$display("rom test done");
	endtask
	task automatic t_prog;
		logic [5:0] of [4] = '{6'h00, 6'h03, 6'h3F, 6'h01};
		logic [7:0] ev [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF};
		// whole-array crc while every cell is still erased
		op(flash_pkg::CMD_CRC, 14'h0000, 1'b1);
		idle();
		rd_reg(flash_pkg::CRC_OFS);
		chk("crc all", crc_ff(flash_pkg::ARRAY_BYTES), rdat);
		// page outside the loader's top 512 bytes, so the loader survives
		op(flash_pkg::CMD_ERASE_PAGE, 14'h3840, 1'b0);
		rd_reg(flash_pkg::CTRL_OFS);
		chk("busy", 32'h1, rdat[flash_pkg::BUSY_POS]);
		idle();
		// a slot loaded then cleared must stay erased after programming
		wr_reg(flash_pkg::DATA_OFS, 32'h00000000);
		op(flash_pkg::CMD_LOAD, 14'h3841, 1'b0);
		op(flash_pkg::CMD_CLEAR_BUF, 14'h3841, 1'b0);
		for (int i = 0; i < 3; i++) begin
			wr_reg(flash_pkg::DATA_OFS, {24'h0, ev[i]});
			op(flash_pkg::CMD_LOAD, 14'h3840 + 14'(of[i]), 1'b0);
			idle();
		end
		op(flash_pkg::CMD_PROG_PAGE, 14'h3840, 1'b0);
		idle();
		foreach (of[i]) begin
			tread(14'h3840 + 14'(of[i]));
			chk("page byte", {24'h0, ev[i]}, v);
		end
		op(flash_pkg::CMD_ERASE_BYTE, 14'h3843, 1'b0);
		idle();
		tread(14'h3843);
		chk("erased byte", 32'hFF, v);
		tread(14'h3840);
		chk("kept byte", 32'h5A, v);
		$display("program test done");
	endtask
	task t_sec;
		op(flash_pkg::CMD_ERASE_SECTOR, 14'h1000, 1'b0);
		rd_reg(flash_pkg::CTRL_OFS);
		chk("busy", 32'h1, rdat[flash_pkg::BUSY_POS]);
		idle();
		tread(14'h17FF);
		chk("sector end", 32'hFF, v);
		op(flash_pkg::CMD_CRC, 14'h1000, 1'b0);
		idle();
		rd_reg(flash_pkg::CRC_OFS);
		chk("crc", crc_ff(flash_pkg::SECTOR_BYTES), rdat);
		wr_reg(flash_pkg::SECURE_OFS, 32'h00000004);
		tread(14'h1000);
		chk("denied", 32'h1, c[flash_pkg::DENIED_POS]);
		chk("hidden", 32'h0, v);
		tread(14'h3840);
		chk("allowed", 32'h0, c[flash_pkg::DENIED_POS]);
		chk("open byte", 32'h5A, v);
		$display("secure test done");
	endtask
	task t_bus;
		wr_reg(8'h20, 32'h00000005);
		chk("wr resp", flash_pkg::RESP_SLVERR, rs);
		rd_reg(8'h24);
		chk("rd resp", flash_pkg::RESP_SLVERR, rs);
		chk("rd data", 32'h0, rdat);
		$display("bus test done");
	endtask
	task automatic t_link;
		logic [7:0] b = 8'hC6;
		for (int i = 7; i >= 0; i--) begin
			@(posedge aclk);
			{prog_clk, prog_data} <= {1'b0, b[i]};
			@(posedge aclk);
			prog_clk <= 1'b1;
		end
		@(posedge aclk);
		prog_clk <= 1'b0;
		rd_reg(flash_pkg::DATA_OFS);
		chk("link byte", 32'hC6, rdat);
		$display("link test done");
	endtask
	task tally_and_finish;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	// limit far above the three long erase and crc runs
	initial begin
		repeat (60000) @(posedge aclk);
		err_total++;
		tally_and_finish();
	end
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, jump_en, call_en} = 8'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, jump_addr} = 64'h0;
		s_axi_wstrb = 4'hF;
		{prog_clk, prog_data} = 2'h0;
		err_total = 0;
		cmp_count = 0;
		rst();
		t_boot();
		t_rom();
		t_prog();
		t_sec();
		t_bus();
		t_link();
		tally_and_finish();
	end
endmodule
